//--- src/link_mon_pkg.sv
/*
 Constants shared by the lane receive-quality monitor.
 Assumes one 100 MHz module clock.
*/
package link_mon_pkg;
  localparam int BIN_W = 6;
  localparam int NUM_BINS = 64;
  localparam int HIT_W = 16;
  localparam logic [15:0] CODE_INF = 16'hFFFF;
  localparam logic [15:0] CODE_SAT = 16'hFFFE;
  localparam logic [15:0] REF_FRAME_BITS = 16'h1540;
  localparam logic [31:0] INTERVAL_BITS = 32'h0098_9680;
  localparam logic [15:0] RST_FIG = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PEAK = 3'b001,
    ST_VAL = 3'b010,
    ST_CALC = 3'b011,
    ST_OUT = 3'b100
  } hist_st_t;
endpackage

//--- src/pam4_fec_link_monitor.sv
/*
 Per-lane receive-quality monitor: histogram eye figures and FEC interval
 samples. Assumes histogram samples arrive at the eye centre ahead of the
 slicer and that FEC decoder reports are synchronous to I_CLK.
*/
// Notes on behaviour
// - Histogram fed by eye-centre samples taken just before the slicer decision.
// - Peak is the bin of most hits between adjacent valleys or the ends.
// - Valley is lowest-hit bin between peaks; its height is that count. Code takes the lowest bin of fixed bins 8-23, 24-39, 40-55.
// - Optical eye ratio: mean gap over sigma sum, report 10log10 of minimum.
// - Electrical eye ratio: half squared gap over variance sum, minimum taken.
// - Transition figure: min of average neighbour peaks over valley height.
// - Figures are unsigned 16-bit in 1/256 dB.
// - Any zero valley gives the all-ones code.
// - Finite figure beyond range saturates to all-ones minus one.
// - Count uncorrectable frames per interval in reference-code equivalents.
// - Scale count by actual frame bits over 5440 when code differs.
// - Bit error ratio is corrected bits over received bits per interval.
// - Max symbol weight is largest per-frame corrected count in interval.
// - Algebraic weight spans 0..t; uncorrectable frames count as t plus one.
// - Max symbol weight is reported without frame-size scaling.
// - Iterative decoders supply bit errors per reference frame as weight.
// - Nominal interval length is advertised on a readable output.
// - Interval ends after a fixed count of received bits.
// - Sample outputs hold results of the last completed interval.
`timescale 1ns/100ps
module pam4_fec_link_monitor (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_SMP_VALID,
  input wire logic [5:0] I_SMP_BIN,
  input wire logic I_HIST_DONE,
  input wire logic I_OPTICAL,
  input wire logic [15:0] I_MEAN [4],
  input wire logic [15:0] I_SIGMA [4],
  input wire logic I_FRM_VALID,
  input wire logic I_FRM_UNCORR,
  input wire logic I_ITERATIVE,
  input wire logic [7:0] I_FRM_CORR,
  input wire logic [7:0] I_T_CAP,
  input wire logic [15:0] I_FRAME_BITS,
  input wire logic [15:0] I_BITS_PER_CLK,
  output logic [15:0] O_SNR,
  output logic [15:0] O_LVL_TRANS,
  output logic O_EYE_UPDATE,
  output logic [31:0] O_UNCORR_FRAMES,
  output logic [31:0] O_BER_ERR_BITS,
  output logic [31:0] O_BER_TOT_BITS,
  output logic [7:0] O_MAX_WEIGHT,
  output logic O_FEC_UPDATE,
  output logic [31:0] O_NOM_INTERVAL
);
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Histogram store; counts saturate so a long run cannot wrap a peak
  logic [15:0] hist_r [64];
  link_mon_pkg::hist_st_t st_r;
  logic [5:0] idx_r;
  logic [1:0] seg_r;
  logic [15:0] best_r;
  logic [15:0] pk_r [4];
  logic [15:0] vl_r [3];
  logic [5:0] vloc_r [3];

  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_bin
      always_ff @(posedge I_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
          hist_r[g] <= 16'h0000;
        end else if (st_r == link_mon_pkg::ST_OUT) begin
          hist_r[g] <= 16'h0000;
        end else if (I_SMP_VALID && I_SMP_BIN == 6'(g) &&
                     st_r == link_mon_pkg::ST_IDLE &&
                     hist_r[g] != 16'hFFFF) begin
          hist_r[g] <= hist_r[g] + 16'h0001;
        end
      end
    end
  endgenerate

  // Valleys are searched first across fixed quarter regions, then peaks
  // between them; a simple split that assumes roughly centred levels.
  logic [15:0] h_cur;
  assign h_cur = hist_r[idx_r];
  logic seg_end;
  assign seg_end = (idx_r[3:0] == 4'hF);

  always_ff @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= link_mon_pkg::ST_IDLE;
      idx_r <= 6'h00;
      seg_r <= 2'h0;
      best_r <= 16'h0000;
      for (int i = 0; i < 4; i++) pk_r[i] <= 16'h0000;
      for (int i = 0; i < 3; i++) begin
        vl_r[i] <= 16'h0000;
        vloc_r[i] <= 6'h00;
      end
    end else begin
      unique case (st_r)
        link_mon_pkg::ST_IDLE: begin
          if (I_HIST_DONE) begin
            st_r <= link_mon_pkg::ST_VAL;
            idx_r <= 6'h08;
            seg_r <= 2'h0;
            best_r <= 16'hFFFF;
          end
        end
        link_mon_pkg::ST_VAL: begin
          if (h_cur <= best_r) begin
            best_r <= h_cur;
            vl_r[seg_r] <= h_cur;
            vloc_r[seg_r] <= idx_r;
          end
          if (idx_r[3:0] == 4'h7 && idx_r != 6'h08) begin
            best_r <= 16'hFFFF;
            if (seg_r == 2'h2) begin
              st_r <= link_mon_pkg::ST_PEAK;
              // An empty region must not keep a peak from the last run
              for (int i = 0; i < 4; i++) pk_r[i] <= 16'h0000;
              idx_r <= 6'h00;
              seg_r <= 2'h0;
              best_r <= 16'h0000;
            end else begin
              seg_r <= seg_r + 2'h1;
              idx_r <= idx_r + 6'h01;
            end
          end else begin
            idx_r <= idx_r + 6'h01;
          end
        end
        link_mon_pkg::ST_PEAK: begin
          if (seg_r != 2'h3 && idx_r == vloc_r[seg_r]) begin
            seg_r <= seg_r + 2'h1;
            best_r <= 16'h0000;
          end else if (h_cur > best_r) begin
            best_r <= h_cur;
            pk_r[seg_r] <= h_cur;
          end
          if (idx_r == 6'h3F) st_r <= link_mon_pkg::ST_CALC;
          idx_r <= idx_r + 6'h01;
        end
        link_mon_pkg::ST_CALC: st_r <= link_mon_pkg::ST_OUT;
        link_mon_pkg::ST_OUT: st_r <= link_mon_pkg::ST_IDLE;
        default: st_r <= link_mon_pkg::ST_IDLE;
      endcase
    end
  end

  // 10log10 of a linear ratio in 8.8 fixed point, via log2 estimate
  function automatic logic [31:0] db_q8(input logic [47:0] num,
                                        input logic [47:0] den);
    logic [5:0] ln, ld;
    logic [47:0] nn, dd;
    logic [31:0] l2;
    ln = 6'h00;
    ld = 6'h00;
    for (int i = 0; i < 48; i++) begin
      if (num[i]) ln = 6'(i);
      if (den[i]) ld = 6'(i);
    end
    nn = num << (6'd47 - ln);
    dd = den << (6'd47 - ld);
    // Linear mantissa interpolation keeps error well under 3 dB
    l2 = ({26'h0, ln} << 8) + {24'h0, nn[46:39]} -
         ({26'h0, ld} << 8) - {24'h0, dd[46:39]};
    // 3.0103 dB per octave; arithmetic shift keeps sub-unity ratios negative
    db_q8 = 32'($signed(l2) * 32'sh0000_0301 >>> 8);
  endfunction

  logic [47:0] snr_n [3];
  logic [47:0] snr_d [3];
  logic [31:0] snr_db [3];
  logic [31:0] lvl_db [3];
  logic [16:0] gap [3];
  generate
    for (g = 0; g < 3; g++) begin : g_eye
      assign gap[g] = {1'b0, I_MEAN[g+1]} - {1'b0, I_MEAN[g]};
      // Products formed at full width so wide level swings do not wrap
      assign snr_n[g] = I_OPTICAL ? 48'(gap[g]) :
        48'(gap[g]) * 48'(gap[g]);
      assign snr_d[g] = I_OPTICAL ?
        48'(I_SIGMA[g+1]) + 48'(I_SIGMA[g]) :
        (48'(I_SIGMA[g+1]) * 48'(I_SIGMA[g+1]) +
         48'(I_SIGMA[g]) * 48'(I_SIGMA[g])) << 1;
      assign snr_db[g] = db_q8(snr_n[g], snr_d[g]);
      assign lvl_db[g] = db_q8(48'(pk_r[g]) + 48'(pk_r[g+1]),
        48'(vl_r[g]) << 1);
    end
  endgenerate

  // Ratios below unity clamp to 0 dB since the field is unsigned
  function automatic logic [15:0] to_u16(input logic [31:0] v);
    if (v[31]) to_u16 = 16'h0000;
    else if (v > 32'h0000_FFFD) to_u16 = link_mon_pkg::CODE_SAT;
    else to_u16 = v[15:0];
  endfunction

  logic [31:0] snr_min, lvl_min;
  always_comb begin
    snr_min = snr_db[0];
    lvl_min = lvl_db[0];
    for (int i = 1; i < 3; i++) begin
      if ($signed(snr_db[i]) < $signed(snr_min)) snr_min = snr_db[i];
      if ($signed(lvl_db[i]) < $signed(lvl_min)) lvl_min = lvl_db[i];
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_SNR <= link_mon_pkg::RST_FIG;
      O_LVL_TRANS <= link_mon_pkg::RST_FIG;
      O_EYE_UPDATE <= 1'b0;
    end else begin
      O_EYE_UPDATE <= (st_r == link_mon_pkg::ST_CALC);
      if (st_r == link_mon_pkg::ST_CALC) begin
        O_SNR <= to_u16(snr_min);
        if (vl_r[0] == 16'h0000 || vl_r[1] == 16'h0000 ||
            vl_r[2] == 16'h0000) begin
          O_LVL_TRANS <= link_mon_pkg::CODE_INF;
        end else begin
          O_LVL_TRANS <= to_u16(lvl_min);
        end
      end
    end
  end

  // FEC interval accumulation; the interval is a fixed received-bit count
  logic [31:0] bits_r, err_r, unc_r;
  logic [7:0] wgt_max_r;
  logic [7:0] frm_wgt;
  logic [31:0] unc_scaled;
  logic interval_end;
  assign frm_wgt = (I_FRM_UNCORR && !I_ITERATIVE) ?
    I_T_CAP + 8'h01 : I_FRM_CORR;
  assign interval_end = (bits_r + {16'h0, I_BITS_PER_CLK}) >=
    link_mon_pkg::INTERVAL_BITS;
  assign unc_scaled = 32'((64'(unc_r) * 64'(I_FRAME_BITS)) /
    64'(link_mon_pkg::REF_FRAME_BITS));

  always_ff @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bits_r <= 32'h0000_0000;
      err_r <= 32'h0000_0000;
      unc_r <= 32'h0000_0000;
      wgt_max_r <= 8'h00;
    end else if (interval_end) begin
      bits_r <= 32'h0000_0000;
      err_r <= 32'h0000_0000;
      unc_r <= 32'h0000_0000;
      wgt_max_r <= 8'h00;
    end else begin
      bits_r <= bits_r + {16'h0, I_BITS_PER_CLK};
      if (I_FRM_VALID) begin
        if (!I_FRM_UNCORR) err_r <= err_r + {24'h0, I_FRM_CORR};
        if (I_FRM_UNCORR) unc_r <= unc_r + 32'h0000_0001;
        if (frm_wgt > wgt_max_r) wgt_max_r <= frm_wgt;
      end
    end
  end

  // Frame reports in the closing cycle are dropped; one frame per interval
  always_ff @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_UNCORR_FRAMES <= 32'h0000_0000;
      O_BER_ERR_BITS <= 32'h0000_0000;
      O_BER_TOT_BITS <= 32'h0000_0000;
      O_MAX_WEIGHT <= 8'h00;
      O_FEC_UPDATE <= 1'b0;
      O_NOM_INTERVAL <= 32'h0000_0000;
    end else begin
      O_NOM_INTERVAL <= link_mon_pkg::INTERVAL_BITS;
      O_FEC_UPDATE <= interval_end;
      if (interval_end) begin
        O_UNCORR_FRAMES <= unc_scaled;
        O_BER_ERR_BITS <= err_r;
        O_BER_TOT_BITS <= bits_r + {16'h0, I_BITS_PER_CLK};
        O_MAX_WEIGHT <= wgt_max_r;
      end
    end
  end
endmodule

//--- test/pam4_fec_link_monitor_properties.sv
/* Concurrent checks on the lane monitor's top ports.
   Assumes one clock and the pin-level active-low reset. */
`timescale 1ns/100ps
module pam4_fec_link_monitor_properties (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_HIST_DONE,
  input wire logic I_ITERATIVE,
  input wire logic [7:0] I_T_CAP,
  input wire logic [15:0] O_SNR,
  input wire logic [15:0] O_LVL_TRANS,
  input wire logic O_EYE_UPDATE,
  input wire logic [31:0] O_UNCORR_FRAMES,
  input wire logic [31:0] O_BER_ERR_BITS,
  input wire logic [31:0] O_BER_TOT_BITS,
  input wire logic [7:0] O_MAX_WEIGHT,
  input wire logic O_FEC_UPDATE,
  input wire logic [31:0] O_NOM_INTERVAL
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  eye_answer_a: assert property (
    $rose(I_HIST_DONE) |-> ##[1:200] O_EYE_UPDATE) else $error("eye late");
  eye_hold_a: assert property (
    !O_EYE_UPDATE |-> $stable(O_SNR) && $stable(O_LVL_TRANS))
    else $error("eye figure moved");
  eye_pulse_a: assert property (O_EYE_UPDATE |=> !O_EYE_UPDATE)
    else $error("eye pulse long");
  fec_hold_a: assert property (
    !O_FEC_UPDATE |-> $stable(O_UNCORR_FRAMES) && $stable(O_MAX_WEIGHT)
    && $stable(O_BER_ERR_BITS)) else $error("sample moved");
  fec_spacing_a: assert property (
    O_FEC_UPDATE |=> (!O_FEC_UPDATE)[*8]) else $error("interval short");
  ber_ratio_a: assert property (O_FEC_UPDATE |->
    O_BER_ERR_BITS <= O_BER_TOT_BITS
    && O_BER_TOT_BITS >= link_mon_pkg::INTERVAL_BITS)
    else $error("ratio bad");
  weight_bound_a: assert property (
    O_FEC_UPDATE && !I_ITERATIVE |-> {1'b0, O_MAX_WEIGHT} <= I_T_CAP + 9'h001)
    else $error("weight over t+1");
  nominal_len_a: assert property (
    O_FEC_UPDATE |-> O_NOM_INTERVAL == link_mon_pkg::INTERVAL_BITS)
    else $error("nominal length");
endmodule

bind pam4_fec_link_monitor pam4_fec_link_monitor_properties props_i (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_HIST_DONE(I_HIST_DONE),
  .I_ITERATIVE(I_ITERATIVE), .I_T_CAP(I_T_CAP), .O_SNR(O_SNR),
  .O_LVL_TRANS(O_LVL_TRANS), .O_EYE_UPDATE(O_EYE_UPDATE),
  .O_UNCORR_FRAMES(O_UNCORR_FRAMES), .O_BER_ERR_BITS(O_BER_ERR_BITS),
  .O_BER_TOT_BITS(O_BER_TOT_BITS), .O_MAX_WEIGHT(O_MAX_WEIGHT),
  .O_FEC_UPDATE(O_FEC_UPDATE), .O_NOM_INTERVAL(O_NOM_INTERVAL));

//--- test/host_reader.sv
/* Host model latching each FEC sample at its update pulse.
   Assumes the pulse is one clock long and values load with it. */
`timescale 1ns/100ps
module host_reader (
  input wire logic i_clk,
  input wire logic i_upd,
  input wire logic [31:0] i_uncorr,
  input wire logic [31:0] i_err,
  input wire logic [7:0] i_wgt,
  output logic [31:0] o_uncorr,
  output logic [31:0] o_err,
  output logic [7:0] o_wgt
);
  // Reads only on the pulse, so a value that lands late is missed
  always_ff @(posedge i_clk) begin
    if (i_upd) begin
      o_uncorr <= i_uncorr;
      o_err <= i_err;
      o_wgt <= i_wgt;
    end
  end
endmodule

//--- test/pam4_fec_link_monitor_tb_top.sv
/* Self-checking bench for the lane monitor and its host reader.
   Assumes the package and design are compiled first. */
`timescale 1ns/100ps
module pam4_fec_link_monitor_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, smp_valid = 1'b0, hist_done = 1'b0;
  logic optical = 1'b1, frm_valid = 1'b0, frm_uncorr = 1'b0;
  logic iterative = 1'b0, eye_upd, fec_upd;
  logic [5:0] smp_bin = 6'h00;
  logic [15:0] mean [4];
  logic [15:0] sigma [4];
  logic [7:0] frm_corr = 8'h00, t_cap = 8'h0F, wgt, h_wgt;
  logic [15:0] frame_bits = 16'h1540, bits_per_clk = 16'hC350, snr, lvl;
  logic [31:0] uncorr, err, tot, nom, h_uncorr, h_err;
  int fails = 0, checks_done = 0, cycles = 0;
  always #5 clk = ~clk;
  pam4_fec_link_monitor pam4_fec_link_monitor_i (
    .I_CLK(clk), .I_RST_N(rst_n), .I_SMP_VALID(smp_valid),
    .I_SMP_BIN(smp_bin), .I_HIST_DONE(hist_done), .I_OPTICAL(optical),
    .I_MEAN(mean), .I_SIGMA(sigma), .I_FRM_VALID(frm_valid),
    .I_FRM_UNCORR(frm_uncorr), .I_ITERATIVE(iterative),
    .I_FRM_CORR(frm_corr), .I_T_CAP(t_cap), .I_FRAME_BITS(frame_bits),
    .I_BITS_PER_CLK(bits_per_clk), .O_SNR(snr), .O_LVL_TRANS(lvl),
    .O_EYE_UPDATE(eye_upd), .O_UNCORR_FRAMES(uncorr), .O_BER_ERR_BITS(err),
    .O_BER_TOT_BITS(tot), .O_MAX_WEIGHT(wgt), .O_FEC_UPDATE(fec_upd),
    .O_NOM_INTERVAL(nom));
  host_reader host_reader_i (.i_clk(clk), .i_upd(fec_upd),
    .i_uncorr(uncorr), .i_err(err), .i_wgt(wgt), .o_uncorr(h_uncorr),
    .o_err(h_err), .o_wgt(h_wgt));
  task automatic results();
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [31:0] v, lo, hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  task automatic wait_for(input bit eye);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(eye ? eye_upd : fec_upd) && n < 400);
    chk({31'h0, n < 400}, 32'h1);
  endtask
  // Four lone hits leave every valley empty
  task automatic eye_run(input logic opt, input logic [15:0] top);
    optical = opt;
    mean[3] = top;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      smp_valid = 1'b1;
      smp_bin = 6'(i * 20);
    end
    @(negedge clk);
    smp_valid = 1'b0;
    hist_done = 1'b1;
    @(negedge clk);
    hist_done = 1'b0;
    wait_for(1'b1);
  endtask
  // One hit per bin as floor, taller peaks in each region; min ratio 3.5
  task automatic ltp_test();
    optical = 1'b1;
    mean[3] = 16'h0300;
    for (int i = 0; i < 75; i++) begin
      @(negedge clk);
      smp_valid = 1'b1;
      smp_bin = (i < 64) ? 6'(i) : (i < 67) ? 6'h04 : (i < 69) ? 6'h1F :
        (i < 72) ? 6'h2F : 6'h3C;
    end
    @(negedge clk);
    smp_valid = 1'b0;
    hist_done = 1'b1;
    @(negedge clk);
    hist_done = 1'b0;
    wait_for(1'b1);
    near(lvl, 16'h04F1, 16'h05F1);
    near(snr, 16'h02F2, 16'h0312);
  endtask
  task automatic eye_test();
    eye_run(1'b1, 16'h0300);
    chk(lvl, link_mon_pkg::CODE_INF);
    near(snr, 16'h02F2, 16'h0312);
    eye_run(1'b0, 16'h0300);
    near(snr, 16'h05F5, 16'h0615);
    eye_run(1'b1, 16'h0280);
    chk(snr, 16'h0000);
    eye_run(1'b1, 16'h0240);
    chk(snr, 16'h0000);
    ltp_test();
  endtask
  task automatic frame(input logic unc, input logic [7:0] corr);
    @(negedge clk);
    frm_valid = 1'b1;
    frm_uncorr = unc;
    frm_corr = corr;
    @(negedge clk);
    frm_valid = 1'b0;
  endtask
  task automatic fec_close(input logic [31:0] u, e, input logic [7:0] s);
    wait_for(1'b0);
    @(negedge clk);
    chk(h_uncorr, u);
    chk(h_err, e);
    chk({24'h0, h_wgt}, {24'h0, s});
    near(tot, 32'h0098_9680, 32'h0099_59D0);
  endtask
  task automatic fec_test();
    wait_for(1'b0);
    frame(1'b0, 8'h03);
    frame(1'b0, 8'h09);
    frame(1'b1, 8'h00);
    frame(1'b1, 8'h00);
    frame(1'b0, 8'h05);
    fec_close(32'h0000_0002, 32'h0000_0011, 8'h10);
    frame_bits = 16'h2A80;
    iterative = 1'b1;
    repeat (3) frame(1'b1, 8'h00);
    frame(1'b0, 8'h14);
    fec_close(32'h0000_0006, 32'h0000_0014, 8'h14);
    fec_close(32'h0000_0000, 32'h0000_0000, 8'h00);
    chk(nom, link_mon_pkg::INTERVAL_BITS);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      results();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      mean[i] = 16'(i * 256);
      sigma[i] = 16'h0040;
    end
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    eye_test();
    fec_test();
    results();
  end
endmodule
